//--- rtl/dsq_chan_if.sv
// bundle between the sequencer and its channel register file
// assumes both ends share clk; no timing of its own
interface dsq_chan_if;
    import dsq_pkg::*;
    logic prog_we;
    logic [1:0] prog_chan;
    logic [15:0] prog_addr;
    logic [15:0] prog_count;
    logic prog_mode_we;
    logic [5:0] prog_mode;
    logic step;
    logic reload;
    logic [1:0] sel_chan;
    logic [3:0][15:0] cur_addr_all;
    logic [3:0][15:0] cur_count_all;
    logic [3:0][5:0] mode_all;
    modport seq (output prog_we, prog_chan, prog_addr, prog_count, prog_mode_we, prog_mode,
                 output step, reload, sel_chan,
                 input cur_addr_all, cur_count_all, mode_all);
    modport regs (input prog_we, prog_chan, prog_addr, prog_count, prog_mode_we, prog_mode,
                  input step, reload, sel_chan,
                  output cur_addr_all, cur_count_all, mode_all);
endinterface

//--- rtl/dsq_chan_regs.sv
// per-channel base, current and mode registers
// assumes the sequencer only steps or reloads the channel it selects
module dsq_chan_regs
    import dsq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    dsq_chan_if.regs ci
);
    logic [3:0][15:0] base_addr_q;
    logic [3:0][15:0] base_cnt_q;
    logic [3:0][15:0] cur_addr_q;
    logic [3:0][15:0] cur_cnt_q;
    logic [3:0][5:0] mode_q;

    // address and count: sequencer action wins over a stray program write
    always_ff @(posedge clk) begin
        if (rst) begin
            base_addr_q <= '0;
            base_cnt_q <= '0;
            cur_addr_q <= '0;
            cur_cnt_q <= '0;
        end else if (ce) begin
            if (ci.reload) begin
                cur_addr_q[ci.sel_chan] <= base_addr_q[ci.sel_chan];
                cur_cnt_q[ci.sel_chan] <= base_cnt_q[ci.sel_chan];
            end else if (ci.step) begin
                cur_addr_q[ci.sel_chan] <= dsq_step_addr(cur_addr_q[ci.sel_chan],
                    mode_q[ci.sel_chan][MODE_DEC_BIT]);
                cur_cnt_q[ci.sel_chan] <= cur_cnt_q[ci.sel_chan] - 16'h0001;
            end else if (ci.prog_we) begin
                base_addr_q[ci.prog_chan] <= ci.prog_addr;
                base_cnt_q[ci.prog_chan] <= ci.prog_count;
                cur_addr_q[ci.prog_chan] <= ci.prog_addr;
                cur_cnt_q[ci.prog_chan] <= ci.prog_count;
            end
        end
    end

    // mode registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= '0;
        end else if (ce && ci.prog_mode_we) begin
            mode_q[ci.prog_chan] <= ci.prog_mode;
        end
    end

    assign ci.cur_addr_all = cur_addr_q;
    assign ci.cur_count_all = cur_cnt_q;
    assign ci.mode_all = mode_q;
endmodule

//--- rtl/dsq_pkg.sv
// constants, field layouts and state codes of the four-channel dma sequencer
// assumes a single clock domain; included by every sequencer file via import
//
// Contract
// - drive high strobe to latch upper address
// - block runs pulse strobe only on upper change
// - upper strobe timed from falling clock edge
// - low memory read strobe on read halves
// - low memory write strobe on write halves
// - outputs released to high impedance when idle
// - io and memory strobes together for i/o transfers
// - step address by direction, decrement count
// - end on count underflow or external end
// - per-channel 16-bit registers, shared 8-bit registers
// - stay idle until unmasked or software request; here software requests are masked like hardware ones
// - requests recognised only while mask clear
// - valid request raises hold, enters active cycle
// - seven one-clock states for normal transfers
// - idle on no request, end, clear
// - first service state waits for hold grant
// - normal timing waits between third and fourth
// - compressed timing waits between second and fourth
// - memory copy: four read, four write states
// - memory copy byte held in temporary register
// - priority encoder picks among simultaneous requests
// - no working state before hold grant
// - autoinitialise reloads current from base on end
package dsq_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int DSQ_NCH = 4;
    localparam int DSQ_AW = 16;
    localparam int DSQ_CW = 16;
    localparam int DSQ_MW = 6;
    localparam int DSQ_RW = 8;

    // ------------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_TYPE_LSB = 0;
    localparam int MODE_AUTOINIT_BIT = 2;
    localparam int MODE_DEC_BIT = 3;
    localparam int MODE_SEL_LSB = 4;
    localparam logic [1:0] XFER_VERIFY = 2'h0;
    localparam logic [1:0] XFER_WRITE = 2'h1;
    localparam logic [1:0] XFER_READ = 2'h2;
    localparam logic [1:0] SEL_DEMAND = 2'h0;
    localparam logic [1:0] SEL_SINGLE = 2'h1;
    localparam logic [1:0] SEL_BLOCK = 2'h2;

    // ------------------------------------------------------------------
    // command register fields and reset values
    // ------------------------------------------------------------------
    localparam int CMD_M2M_BIT = 0;
    localparam int CMD_DISABLE_BIT = 2;
    localparam int CMD_COMPRESSED_BIT = 3;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'hf;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int STATUS_REQ_LSB = 4;

    // ------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [14:0] {
        ST_IDLE = 15'h0001,
        ST_HOLD = 15'h0002,
        ST_S1 = 15'h0004,
        ST_S2 = 15'h0008,
        ST_S3 = 15'h0010,
        ST_WAIT = 15'h0020,
        ST_S4 = 15'h0040,
        ST_M11 = 15'h0080,
        ST_M12 = 15'h0100,
        ST_M13 = 15'h0200,
        ST_M14 = 15'h0400,
        ST_M21 = 15'h0800,
        ST_M22 = 15'h1000,
        ST_M23 = 15'h2000,
        ST_M24 = 15'h4000
    } dsq_state_e;

    // address step shared by the register file and the look-ahead compare
    function automatic logic [15:0] dsq_step_addr(input logic [15:0] a, input logic dec);
        return dec ? a - 16'h0001 : a + 16'h0001;
    endfunction

endpackage

//--- rtl/dsq_prio.sv
// fixed priority encoder, channel 0 highest
// assumes requests already masked by the caller
module dsq_prio
    import dsq_pkg::*;
(
    input wire logic [3:0] req,
    output logic valid,
    output logic [1:0] idx
);
    // scan from the lowest priority so the highest wins last
    always_comb begin
        valid = |req;
        idx = 2'h0;
        for (int i = DSQ_NCH - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = i[1:0];
            end
        end
    end
endmodule

//--- rtl/dsq_top.sv
// four-channel dma sequencer: idle/active cycles, transfer states, bus strobes
// assumes pins arrive asynchronously and are synchronised here; one clock, clk
module dsq_top
    import dsq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic master_clear,
    input wire logic prog_we,
    input wire logic [1:0] prog_chan,
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] prog_count,
    input wire logic prog_mode_we,
    input wire logic [5:0] prog_mode,
    input wire logic cmd_we,
    input wire logic [7:0] cmd_wdata,
    input wire logic [3:0] mask_set,
    input wire logic [3:0] mask_clear,
    input wire logic [3:0] sw_request_set,
    input wire logic status_clear,
    input wire logic [3:0] channel_request,
    input wire logic bus_hold_grant,
    input wire logic ready,
    input wire logic end_of_process_n_in,
    input wire logic [7:0] data_in,
    output logic bus_hold_request,
    output logic [3:0] channel_grant,
    output logic address_enable,
    output logic upper_addr_strobe,
    output logic [7:0] addr_out,
    output logic addr_oe,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic mem_read_strobe_n,
    output logic mem_write_strobe_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n,
    output logic ctrl_oe,
    output logic end_of_process_n_out,
    output logic end_of_process_n_oe,
    output logic [7:0] status,
    output logic [7:0] command,
    output logic [3:0] mask,
    output logic [7:0] temp_data
);

    // ------------------------------------------------------------------
    // state decode helpers
    // ------------------------------------------------------------------

    // read half of a memory copy
    function automatic logic is_m1(input dsq_state_e s);
        return s inside {ST_M11, ST_M12, ST_M13, ST_M14};
    endfunction

    // write half of a memory copy
    function automatic logic is_m2(input dsq_state_e s);
        return s inside {ST_M21, ST_M22, ST_M23, ST_M24};
    endfunction

    // states that own the system buses
    function automatic logic is_active(input dsq_state_e s);
        return !(s inside {ST_IDLE, ST_HOLD});
    endfunction

    // channel whose registers a state works on
    function automatic logic [1:0] chan_of(input dsq_state_e s, input logic [1:0] c);
        return is_m1(s) ? 2'h0 : (is_m2(s) ? 2'h1 : c);
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [14:0] sync1_q;
    logic [14:0] sync2_q;
    logic [3:0] req_s;
    logic grant_s;
    logic ready_s;
    logic eop_n_s;
    logic [7:0] data_s;

    // two flops per pin; only the second stage is looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 15'h0040;
            sync2_q <= 15'h0040;
        end else if (ce) begin
            sync1_q <= {data_in, end_of_process_n_in, ready, bus_hold_grant, channel_request};
            sync2_q <= sync1_q;
        end
    end

    assign req_s = sync2_q[3:0];
    assign grant_s = sync2_q[4];
    assign ready_s = sync2_q[5];
    assign eop_n_s = sync2_q[6];
    assign data_s = sync2_q[14:7];

    // ------------------------------------------------------------------
    // channel registers and priority
    // ------------------------------------------------------------------
    dsq_chan_if ci ();

    dsq_chan_regs u_regs (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .ci(ci)
    );

    logic [3:0] mask_q;
    logic [3:0] sw_req_q;
    logic [7:0] cmd_q;
    logic [3:0] eff_req;
    logic any_req;
    logic [1:0] win;

    // a disabled controller sees no requests at all
    assign eff_req = cmd_q[CMD_DISABLE_BIT] ? 4'h0
                   : (req_s | sw_req_q) & ~mask_q;

    dsq_prio u_prio (
        .req(eff_req),
        .valid(any_req),
        .idx(win)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    dsq_state_e st_q;
    dsq_state_e st_d;
    logic [1:0] chan_q;
    logic [1:0] chan_d;
    logic eop_seen_q;
    logic step;
    logic reload;
    logic finish;
    logic tc_hit;
    logic [1:0] cur_chan;
    logic [5:0] cur_mode;
    logic [15:0] cur_addr;
    logic [15:0] next_addr;
    logic rdy;
    logic more;

    assign cur_chan = chan_of(st_q, chan_q);
    assign cur_mode = ci.mode_all[chan_q];
    assign cur_addr = ci.cur_addr_all[cur_chan];
    assign next_addr = dsq_step_addr(cur_addr, ci.mode_all[cur_chan][MODE_DEC_BIT]);
    // verify transfers never wait on ready
    assign rdy = ready_s || (cur_mode[MODE_TYPE_LSB +: 2] == XFER_VERIFY);
    // block keeps going; demand keeps going while its request stands
    assign more = (cur_mode[MODE_SEL_LSB +: 2] == SEL_BLOCK)
               || (cur_mode[MODE_SEL_LSB +: 2] == SEL_DEMAND && req_s[chan_q]);

    // next state; every active state lasts one clock unless ready holds it
    always_comb begin
        st_d = st_q;
        chan_d = chan_q;
        step = 1'b0;
        tc_hit = 1'b0;
        finish = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                if (any_req) begin
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!any_req) begin
                    st_d = ST_IDLE;
                end else if (grant_s) begin
                    chan_d = win;
                    // first transfer always loads the upper latch
                    st_d = (cmd_q[CMD_M2M_BIT] && win == 2'h0) ? ST_M11 : ST_S1;
                end
            end
            ST_S1: st_d = ST_S2;
            ST_S2: begin
                if (!cmd_q[CMD_COMPRESSED_BIT]) begin
                    st_d = ST_S3;
                end else begin
                    st_d = rdy ? ST_S4 : ST_WAIT;
                end
            end
            ST_S3: st_d = rdy ? ST_S4 : ST_WAIT;
            ST_WAIT: begin
                if (rdy) begin
                    st_d = ST_S4;
                end
            end
            ST_S4: begin
                step = 1'b1;
                tc_hit = (ci.cur_count_all[chan_q] == 16'h0000);
                finish = tc_hit || eop_seen_q;
                if (finish || !more) begin
                    st_d = ST_IDLE;
                end else if (next_addr[15:8] != cur_addr[15:8]) begin
                    st_d = ST_S1;
                end else begin
                    st_d = ST_S2;
                end
            end
            ST_M11: st_d = ST_M12;
            ST_M12: st_d = ST_M13;
            ST_M13: begin
                if (ready_s) begin
                    st_d = ST_M14;
                end
            end
            ST_M14: begin
                step = 1'b1;
                st_d = ST_M21;
            end
            ST_M21: st_d = ST_M22;
            ST_M22: st_d = ST_M23;
            ST_M23: begin
                if (ready_s) begin
                    st_d = ST_M24;
                end
            end
            ST_M24: begin
                step = 1'b1;
                tc_hit = (ci.cur_count_all[1] == 16'h0000);
                finish = tc_hit || eop_seen_q;
                st_d = finish ? ST_IDLE : ST_M11;
            end
            default: st_d = ST_IDLE;
        endcase
        if (master_clear) begin
            st_d = ST_IDLE;
        end
    end

    assign reload = finish && ci.mode_all[cur_chan][MODE_AUTOINIT_BIT];

    // state and selected channel
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            chan_q <= 2'h0;
        end else if (ce) begin
            st_q <= st_d;
            chan_q <= chan_d;
        end
    end

    // an external end seen at any time in service ends it at the next S4 or M24
    always_ff @(posedge clk) begin
        if (rst) begin
            eop_seen_q <= 1'b0;
        end else if (ce) begin
            if (is_active(st_q) && !eop_n_s) begin
                eop_seen_q <= 1'b1;
            end else if (!is_active(st_q)) begin
                eop_seen_q <= 1'b0;
            end
        end
    end

    // register file hookup; master clear suppresses any step in flight
    assign ci.prog_we = prog_we;
    assign ci.prog_chan = prog_chan;
    assign ci.prog_addr = prog_addr;
    assign ci.prog_count = prog_count;
    assign ci.prog_mode_we = prog_mode_we;
    assign ci.prog_mode = prog_mode;
    assign ci.step = step && !master_clear;
    assign ci.reload = reload && !master_clear;
    assign ci.sel_chan = cur_chan;

    // ------------------------------------------------------------------
    // shared registers: command, mask, request, status, temporary
    // ------------------------------------------------------------------
    logic [3:0] end_bit;
    logic [7:0] status_q;
    logic [7:0] temp_q;

    assign end_bit = (finish && !master_clear) ? (4'h1 << cur_chan) : 4'h0;

    // command register
    always_ff @(posedge clk) begin
        if (rst || (ce && master_clear)) begin
            cmd_q <= CMD_RESET;
        end else if (ce && cmd_we) begin
            cmd_q <= cmd_wdata;
        end
    end

    // mask: hardware set at end without autoinit wins over a clear
    always_ff @(posedge clk) begin
        if (rst || (ce && master_clear)) begin
            mask_q <= MASK_RESET;
        end else if (ce) begin
            mask_q <= (mask_q & ~mask_clear) | mask_set
                    | (reload ? 4'h0 : end_bit);
        end
    end

    // software requests stand until served; a copy ends on ch1 but must drop ch0's too
    always_ff @(posedge clk) begin
        if (rst || (ce && master_clear)) begin
            sw_req_q <= 4'h0;
        end else if (ce) begin
            sw_req_q <= (sw_req_q & ~(end_bit | (4'(finish) << chan_q)))
                      | sw_request_set;
        end
    end

    // status: sticky end flags low, live requests high; set beats clear
    always_ff @(posedge clk) begin
        if (rst || (ce && master_clear)) begin
            status_q <= STATUS_RESET;
        end else if (ce) begin
            status_q[3:0] <= (status_clear ? 4'h0 : status_q[3:0]) | end_bit;
            status_q[STATUS_REQ_LSB +: 4] <= req_s | sw_req_q;
        end
    end

    // byte read in the first half is kept for the write half
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_q <= 8'h00;
        end else if (ce && st_q == ST_M14) begin
            temp_q <= data_s;
        end
    end

    // ------------------------------------------------------------------
    // pin outputs, registered from the next state; the end pulse from the current state's count check
    // ------------------------------------------------------------------
    logic [1:0] chan_nx;
    logic [15:0] addr_nx;
    logic [1:0] type_nx;
    logic act_nx;
    logic strobe_nx;
    logic rd_nx;
    logic wr_nx;
    logic strobe_pend_q;

    assign chan_nx = chan_of(st_d, chan_d);
    // the step lands on this same edge, so use the stepped value here
    assign addr_nx = (step && chan_nx == cur_chan) ? next_addr : ci.cur_addr_all[chan_nx];
    assign type_nx = ci.mode_all[chan_d][MODE_TYPE_LSB +: 2];
    assign act_nx = is_active(st_d);
    assign strobe_nx = st_d inside {ST_S1, ST_M11, ST_M21};
    assign rd_nx = st_d inside {ST_S2, ST_S3, ST_WAIT, ST_S4};
    assign wr_nx = st_d inside {ST_M22, ST_M23, ST_M24};

    // bus ownership and addresses; released when idle or waiting for grant
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_hold_request <= 1'b0;
            address_enable <= 1'b0;
            addr_oe <= 1'b0;
            ctrl_oe <= 1'b0;
            addr_out <= 8'h00;
            channel_grant <= 4'h0;
        end else if (ce) begin
            bus_hold_request <= (st_d != ST_IDLE);
            address_enable <= act_nx;
            addr_oe <= act_nx;
            ctrl_oe <= act_nx;
            addr_out <= addr_nx[7:0];
            channel_grant <= (act_nx && !is_m1(st_d) && !is_m2(st_d))
                           ? (4'h1 << chan_d) : 4'h0;
        end
    end

    // data lines carry the upper address byte or the held copy byte
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            strobe_pend_q <= 1'b0;
        end else if (ce) begin
            data_out <= strobe_nx ? addr_nx[15:8] : temp_q;
            data_oe <= strobe_nx || wr_nx;
            strobe_pend_q <= strobe_nx;
        end
    end

    // falling-edge retime gives the latch half a clock of address setup
    always_ff @(negedge clk) begin
        if (rst) begin
            upper_addr_strobe <= 1'b0;
        end else if (ce) begin
            upper_addr_strobe <= strobe_pend_q;
        end
    end

    // read and write strobes; i/o and memory move together except in copies, which move memory only; verify moves none
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_read_strobe_n <= 1'b1;
            mem_write_strobe_n <= 1'b1;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
        end else if (ce) begin
            mem_read_strobe_n <= !((rd_nx && type_nx == XFER_READ)
                               || st_d inside {ST_M12, ST_M13, ST_M14});
            io_write_strobe_n <= !(rd_nx && type_nx == XFER_READ);
            mem_write_strobe_n <= !((rd_nx && type_nx == XFER_WRITE) || wr_nx);
            io_read_strobe_n <= !(rd_nx && type_nx == XFER_WRITE);
        end
    end

    // end pulse on terminal count, open drain: enable means pull low
    always_ff @(posedge clk) begin
        if (rst) begin
            end_of_process_n_out <= 1'b1;
            end_of_process_n_oe <= 1'b0;
        end else if (ce) begin
            end_of_process_n_out <= !(tc_hit && !master_clear);
            end_of_process_n_oe <= tc_hit && !master_clear;
        end
    end

    assign status = status_q;
    assign command = cmd_q;
    assign mask = mask_q;
    assign temp_data = temp_q;

endmodule

//--- verif/dsq_host_model.sv
// far side: processor hold handshake and a byte memory
// assumes slow picks a memory holding ready low three clocks in four
module dsq_host_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic bus_hold_request,
    input wire logic mem_read_strobe_n,
    input wire logic [7:0] addr_out,
    output logic bus_hold_grant = 1'b0,
    output logic ready,
    output logic [7:0] data_in
);
    logic [1:0] cnt_q = 2'h0;
    // grant a clock after the request, dropped a clock after it
    always_ff @(posedge clk) begin
        bus_hold_grant <= bus_hold_request;
        cnt_q <= cnt_q + 2'h1;
    end
    assign ready = !slow || cnt_q == 2'h3;
    // byte follows the address; inverted while not read, not a stale copy
    assign data_in = mem_read_strobe_n ? ~addr_out : addr_out ^ 8'h5a;
endmodule

//--- verif/dsq_top_chk.sv
// port checker for the dma sequencer
// assumes binding onto dsq_top, one clock, reset rst
module dsq_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic master_clear,
    input wire logic bus_hold_grant,
    input wire logic bus_hold_request,
    input wire logic [3:0] channel_grant,
    input wire logic upper_addr_strobe,
    input wire logic addr_oe,
    input wire logic ctrl_oe,
    input wire logic mem_read_strobe_n,
    input wire logic mem_write_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic end_of_process_n_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // bus ownership and strobe relations
    a_idle_off: assert property (!bus_hold_request |-> !addr_oe && !ctrl_oe)
        else $error("outputs driven while idle");
    a_grant_first: assert property ($rose(ctrl_oe) |-> $past(bus_hold_grant))
        else $error("active before grant");
    a_strobe_one: assert property (upper_addr_strobe |=> !upper_addr_strobe)
        else $error("strobe too long");
    a_strobe_owned: assert property (upper_addr_strobe && !$past(master_clear) |-> addr_oe)
        else $error("strobe off cycle");
    a_read_pair: assert property (!mem_read_strobe_n && |channel_grant |-> !io_write_strobe_n)
        else $error("read unpaired");
    a_halves_apart: assert property (ctrl_oe |-> mem_read_strobe_n || mem_write_strobe_n)
        else $error("read and write together");
    a_grant_single: assert property ($onehot0(channel_grant))
        else $error("two grants");
    a_end_pulse: assert property (end_of_process_n_oe |=> !end_of_process_n_oe)
        else $error("end pulse long");
    a_clear_idle: assert property (master_clear |=> !bus_hold_request && !ctrl_oe)
        else $error("clear ignored");
    // main scenarios reached
    c_strobe: cover property (upper_addr_strobe);
    c_copy_write: cover property (ctrl_oe && !mem_write_strobe_n && channel_grant == 4'h0);
    c_end: cover property (end_of_process_n_oe);
endmodule
bind dsq_top dsq_top_chk chk (.*);

//--- verif/dsq_top_tb.sv
// bench: block read, masked request, memory copy, external end, clear
// assumes the host model beside the sequencer and the bound checker
module dsq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, master_clear = 1'b0, slow = 1'b0, ext_n = 1'b1;
    logic prog_we = 1'b0, prog_mode_we = 1'b0, cmd_we = 1'b0, status_clear = 1'b0;
    logic [1:0] prog_chan = 2'h0;
    logic [15:0] prog_addr = 16'h0000, prog_count = 16'h0000;
    logic [5:0] prog_mode = 6'h00;
    logic [7:0] cmd_wdata = 8'h00, data_in, addr_out, data_out, status, command, temp_data;
    logic [3:0] mask_set = 4'h0, mask_clear = 4'h0, sw_request_set = 4'h0;
    logic [3:0] channel_request = 4'h0, channel_grant, mask;
    logic bus_hold_grant, ready, end_of_process_n_in, bus_hold_request, address_enable;
    logic upper_addr_strobe, addr_oe, data_oe, mem_read_strobe_n, mem_write_strobe_n, ctrl_oe;
    logic io_read_strobe_n, io_write_strobe_n, end_of_process_n_out, end_of_process_n_oe;
    int fails = 0, n_compared = 0, n_strobe = 0, n_end = 0;
    // open-drain end line with pull-up
    assign end_of_process_n_in = ext_n && !end_of_process_n_oe;
    dsq_top uut (.*);
    dsq_host_model host (.*);
    initial begin
        forever #20 clk = ~clk;
    end
    // strobes counted as they happen
    always @(posedge upper_addr_strobe) n_strobe++;
    always @(negedge end_of_process_n_out) n_end++;
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish(input int late);
        fails += late;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // bounded wait for the hold request level
    task automatic hold_is(input logic v, input int bound);
        int i;
        for (i = 0; i < bound && bus_hold_request !== v; i++) tick();
        if (i == bound) tally_and_finish(1);
    endtask
    // one-clock pulses are all dropped together after the edge
    task automatic pulse();
        tick();
        {prog_we, prog_mode_we, cmd_we, master_clear, status_clear, mask_clear, sw_request_set} = 13'h0;
        tick();
    endtask
    task automatic prog(input logic [1:0] ch, input logic [15:0] a, c, input logic [5:0] m);
        {prog_chan, prog_addr, prog_count, prog_mode} = {ch, a, c, m};
        {prog_we, prog_mode_we} = 2'h3;
        pulse();
    endtask
    initial begin
        tick(4);
        rst = 1'b0;
        cmp(16'(mask), 16'h000f);
        cmp(16'(command), 16'h0000);
        prog(2'h2, 16'h00fe, 16'h0002, 6'h22);
        {mask_clear, channel_request} = 8'h44;
        pulse();
        hold_is(1'b1, 20);
        hold_is(1'b0, 200);
        cmp(16'(n_strobe), 16'h0002);
        cmp(16'(status), 16'h0044);
        cmp(16'(mask), 16'h000f);
        $display("block read done");
        {sw_request_set, status_clear} = 5'h11;
        pulse();
        tick(8);
        cmp(16'(bus_hold_request), 16'h0000);
        cmp(16'(status), 16'h00c0);
        $display("masked request done");
        {cmd_wdata, cmd_we, slow} = 10'h007;
        prog(2'h0, 16'h1034, 16'h0000, 6'h22);
        prog(2'h1, 16'h2000, 16'h0000, 6'h25);
        {mask_clear, sw_request_set} = 8'h31;
        pulse();
        hold_is(1'b1, 20);
        hold_is(1'b0, 200);
        cmp(16'(temp_data), 16'h006e);
        cmp(16'(mask[1]), 16'h0000);
        cmp(16'(status[1]), 16'h0001);
        $display("memory copy done");
        {cmd_wdata, cmd_we} = 9'h011;
        prog(2'h2, 16'h0300, 16'h00ff, 6'h26);
        mask_clear = 4'h4;
        pulse();
        hold_is(1'b1, 20);
        tick(10);
        {ext_n, channel_request} = 5'h00;
        tick(3);
        ext_n = 1'b1;
        hold_is(1'b0, 40);
        cmp(16'(mask[2]), 16'h0000);
        $display("external end done");
        {mask_clear, channel_request} = 8'h44;
        pulse();
        hold_is(1'b1, 20);
        tick(5);
        master_clear = 1'b1;
        pulse();
        cmp(16'(mask), 16'h000f);
        cmp(16'(bus_hold_request), 16'h0000);
        cmp(16'(n_end), 16'h0002);
        $display("master clear done");
        tally_and_finish(0);
    end
endmodule
